//--- rtl/rps_pkg.sv
// Package: constants and types for ROM protection and system configuration
`default_nettype none
package rps_pkg;
  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int PROG_WORDS = 4096;
  localparam int INFO_WORDS = 32;
  localparam int PROG_AW = 12;
  localparam int INFO_AW = 5;
  localparam logic [4:0] CFG_INFO_ADDR = 5'h01;
  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int CFG_PROTECT_BIT = 15;
  localparam int CFG_XRST_BIT = 14;
  localparam int CFG_UVR_HI = 13;
  localparam int CFG_UVR_LO = 10;
  localparam int CFG_WD_HI = 9;
  localparam int CFG_WD_LO = 8;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int RDIDX = 'h106;
  localparam logic [11:0] ADDR_RDELAY = 12'h418;
  localparam logic [11:0] ADDR_SYSTEM_CONFIG_WORD = 12'h41C;
  localparam logic [11:0] ADDR_STATUS = 12'h420;
  localparam logic [1:0] RDELAY_RST = 2'h1;
  localparam logic [15:0] SYSTEM_CONFIG_WORD_RST = 16'h0000;
  // ****************************************
  // Vectors and programmer commands
  // ****************************************
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] IRQ_VECTOR = 12'h004;
  localparam logic [15:0] ERASED_WORD = 16'h0000;
  typedef enum logic [1:0] {RPS_RD = 2'h0, RPS_WR = 2'h1, RPS_ERASE = 2'h3} rps_cmd_t;
  typedef enum logic [1:0] {RPS_IDLE = 2'b00, RPS_ERASING = 2'b01} rps_state_t;
  typedef struct packed {
    logic valid;
    rps_cmd_t cmd;
    logic info;
    logic [11:0] addr;
    logic [15:0] wdata;
  } rps_prog_req_t;
  typedef struct packed {
    logic valid;
    logic refused;
    logic [15:0] rdata;
  } rps_prog_rsp_t;
  typedef struct packed {
    logic pinResetEn;
    logic [3:0] uvrLevel;
    logic wdRun;
    logic wdIdle;
  } rps_cfg_out_t;
endpackage : rps_pkg
`default_nettype wire

//--- rtl/rps_rom_protect_sysconfig.sv
// Module: program/information ROM with protection, config decode and vectors
`default_nettype none
// Function
// - Unprotected: programmer reads and writes both memories
// - Protected: only information memory readable
// - Protection bit is config bit fifteen
// - Protection clears only on reset or after full zero erase
// - 4K program words, 32 information words
// - Two-bit read delay, reset 01, 4-16ns
// - Reset fetches address zero, registers default
// - Interrupt pushes PC, jumps to four
// - External reset pin honoured when bit14 set
// - Bits 13-10 select sixteen ascending thresholds
// - Watchdog 0X off, 10 running only
// - Watchdog code 11 always enabled
module rps_rom_protect_sysconfig #(
  parameter int PROG_DEPTH = 4096,
  parameter int INFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  // Programmer port
  input wire rps_pkg::rps_prog_req_t progReq,
  output rps_pkg::rps_prog_rsp_t progRsp,
  output logic progReady,
  // CPU fetch side
  input wire logic irqTake,
  output logic [11:0] pc,
  output logic [11:0] stackTop,
  output logic [3:0] stackDepth,
  // External reset pin
  input wire logic extResetPin_n,
  output logic pinResetReq,
  // Decoded configuration
  output rps_pkg::rps_cfg_out_t cfgOut,
  output logic [1:0] readDelay
);
  import rps_pkg::*;

  // Depth check, address widths are fixed for these memories
  if (PROG_DEPTH != PROG_WORDS || INFO_DEPTH != INFO_WORDS)
  begin : g_bad_depth
    $error("Memory depths must match 4096 and 32");
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] progMem [PROG_DEPTH];
  logic [15:0] infoMem [INFO_DEPTH];
  logic [15:0] system_config_word;
  logic [1:0] rdDelay;
  logic allErased;
  rps_state_t state;
  logic [11:0] eraseAddr;
  logic [11:0] stack [8];
  logic [2:0] sp;
  logic [3:0] depth;

  // Protection bit view
  function automatic logic isProtected(input logic [15:0] w);
    return w[CFG_PROTECT_BIT];
  endfunction : isProtected

  // ****************************************
  // Avalon-MM slave, one wait cycle on reads
  // ****************************************
  logic rdPend;
  logic busHit;
  assign busHit = avs_address == ADDR_RDELAY || avs_address == ADDR_SYSTEM_CONFIG_WORD || avs_address == ADDR_STATUS;
  assign avs_waitrequest = avs_read && !rdPend;

  // Read pipeline stage
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rdPend <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end
    else
    begin
      rdPend <= avs_read && !rdPend;
      avs_response_err <= (avs_read || avs_write) && !busHit;
      unique case (avs_address)
        ADDR_RDELAY: avs_readdata <= {30'h0, rdDelay};
        ADDR_SYSTEM_CONFIG_WORD: avs_readdata <= {16'h0000, system_config_word};
        ADDR_STATUS: avs_readdata <= {28'h0000_000, depth[2:0], allErased};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Read delay register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rdDelay <= RDELAY_RST;
    end
    else if (avs_write && avs_address == ADDR_RDELAY && avs_byteenable[0])
    begin
      rdDelay <= avs_writedata[1:0];
    end
  end
  assign readDelay = rdDelay;

  // ****************************************
  // Programmer access and erase
  // ****************************************
  assign progReady = state == RPS_IDLE;
  logic progLockedRd;
  assign progLockedRd = isProtected(system_config_word) && !progReq.info;

  // Erase walker
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state <= RPS_IDLE;
      eraseAddr <= 12'h000;
    end
    else
    begin
      unique case (state)
        RPS_IDLE:
        begin
          if (progReq.valid && progReq.cmd == RPS_ERASE)
          begin
            state <= RPS_ERASING;
            eraseAddr <= 12'h000;
          end
        end
        RPS_ERASING:
        begin
          eraseAddr <= eraseAddr + 12'h001;
          if (eraseAddr == 12'hFFF)
          begin
            state <= RPS_IDLE;
          end
        end
        default: state <= RPS_IDLE;
      endcase
    end
  end

  // Erase span watch, cycles spent in the erase walk
  logic [12:0] eraseSpan;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      eraseSpan <= 13'h0000;
    end
    else if (state == RPS_ERASING)
    begin
      eraseSpan <= eraseSpan + 13'h0001;
    end
    else
    begin
      eraseSpan <= 13'h0000;
    end
  end

  // Erase-complete flag, lost on any non-zero program write
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      allErased <= 1'b0;
    end
    else if (state == RPS_ERASING && eraseAddr == 12'hFFF)
    begin
      allErased <= 1'b1;
    end
    else if (progReady && progReq.valid && progReq.cmd == RPS_WR && !progReq.info
             && progReq.wdata != ERASED_WORD)
    begin
      allErased <= 1'b0;
    end
  end

  // Memory writes
  always_ff @(posedge sys_clk)
  begin
    if (state == RPS_ERASING)
    begin
      progMem[eraseAddr] <= ERASED_WORD;
    end
    else if (progReq.valid && progReq.cmd == RPS_WR && !progReq.info && !isProtected(system_config_word))
    begin
      progMem[progReq.addr] <= progReq.wdata;
    end
    if (progReady && progReq.valid && progReq.cmd == RPS_WR && progReq.info)
    begin
      infoMem[progReq.addr[INFO_AW-1:0]] <= progReq.wdata;
    end
  end

  // Configuration word, protection clear gated by erase
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      system_config_word <= SYSTEM_CONFIG_WORD_RST;
    end
    else if (progReady && progReq.valid && progReq.cmd == RPS_WR && progReq.info
             && progReq.addr[INFO_AW-1:0] == CFG_INFO_ADDR)
    begin
      system_config_word[14:0] <= progReq.wdata[14:0];
      if (progReq.wdata[CFG_PROTECT_BIT] || allErased)
      begin
        system_config_word[CFG_PROTECT_BIT] <= progReq.wdata[CFG_PROTECT_BIT];
      end
    end
  end

  // Programmer read answer
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      progRsp <= '0;
    end
    else
    begin
      progRsp.valid <= progReady && progReq.valid && progReq.cmd == RPS_RD;
      progRsp.refused <= progLockedRd;
      if (progReq.info)
      begin
        progRsp.rdata <= infoMem[progReq.addr[INFO_AW-1:0]];
      end
      else if (progLockedRd)
      begin
        progRsp.rdata <= 16'h0000;
      end
      else
      begin
        progRsp.rdata <= progMem[progReq.addr];
      end
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  logic pinS1;
  logic pinS2;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pinS1 <= 1'b1;
      pinS2 <= 1'b1;
    end
    else
    begin
      pinS1 <= extResetPin_n;
      pinS2 <= pinS1;
    end
  end
  assign cfgOut.pinResetEn = system_config_word[CFG_XRST_BIT];
  assign pinResetReq = system_config_word[CFG_XRST_BIT] && !pinS2;
  assign cfgOut.uvrLevel = system_config_word[CFG_UVR_HI:CFG_UVR_LO];
  assign cfgOut.wdRun = system_config_word[CFG_WD_HI];
  assign cfgOut.wdIdle = system_config_word[CFG_WD_HI] && system_config_word[CFG_WD_LO];

  // ****************************************
  // Program counter and vector stack
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pc <= RESET_VECTOR;
      sp <= 3'h0;
      depth <= 4'h0;
    end
    else if (irqTake)
    begin
      stack[sp] <= pc;
      sp <= sp + 3'h1;
      depth <= (depth == 4'h8) ? depth : depth + 4'h1;
      pc <= IRQ_VECTOR;
    end
    else
    begin
      pc <= pc + 12'h001;
    end
  end
  assign stackTop = stack[sp - 3'h1];
  assign stackDepth = depth;

  // ****************************************
  // Assertions
  // ****************************************
  // End of an erase walk
  sequence s_erase_end;
    $fell(state == RPS_ERASING);
  endsequence
  a_irq_vector_jump: assert property (@(posedge sys_clk) disable iff (!rstn)
    irqTake |=> pc == IRQ_VECTOR && stackTop == $past(pc))
    else $error("irq vector wrong");
  a_reset_pc_zero: assert property (@(posedge sys_clk)
    !rstn |=> pc == RESET_VECTOR && rdDelay == RDELAY_RST)
    else $error("reset defaults wrong");
  a_protect_refuse_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    progReq.valid && progReq.cmd == RPS_RD && !progReq.info && system_config_word[15] && progReady
    |=> progRsp.refused && progRsp.rdata == 16'h0000)
    else $error("protected read leaked");
  a_open_read_ok: assert property (@(posedge sys_clk) disable iff (!rstn)
    progReq.valid && progReq.cmd == RPS_RD && !system_config_word[15] && progReady |=> progRsp.valid && !progRsp.refused)
    else $error("open read refused");
  a_clear_needs_erase: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(system_config_word[15]) |-> $past(allErased))
    else $error("protection cleared early");
  a_pin_reset_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    !system_config_word[14] |-> !pinResetReq)
    else $error("pin reset not gated");
  a_uvr_level_map: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfgOut.uvrLevel == system_config_word[13:10])
    else $error("threshold map wrong");
  a_wd_mode_map: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cfgOut.wdIdle |-> cfgOut.wdRun) and (!system_config_word[9] |-> !cfgOut.wdRun))
    else $error("watchdog map wrong");
  a_wd_code_ten: assert property (@(posedge sys_clk) disable iff (!rstn)
    system_config_word[CFG_WD_HI:CFG_WD_LO] == 2'b10 |-> cfgOut.wdRun && !cfgOut.wdIdle)
    else $error("watchdog run-only mode wrong");
  a_wd_code_eleven: assert property (@(posedge sys_clk) disable iff (!rstn)
    system_config_word[CFG_WD_HI:CFG_WD_LO] == 2'b11 |-> cfgOut.wdRun && cfgOut.wdIdle)
    else $error("watchdog always mode wrong");
  a_erase_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    state == RPS_ERASING |-> eraseSpan < 13'(PROG_WORDS))
    else $error("erase too long");
  a_erase_done: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_erase_end |-> eraseSpan == 13'(PROG_WORDS) && allErased)
    else $error("erase length wrong");
  a_erased_lost: assert property (@(posedge sys_clk) disable iff (!rstn)
    progReady && progReq.valid && progReq.cmd == RPS_WR && !progReq.info && progReq.wdata != ERASED_WORD
    |=> !allErased)
    else $error("erase flag kept after write");
  a_rdelay_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    avs_write && avs_address == ADDR_RDELAY && avs_byteenable[0] |=> readDelay == $past(avs_writedata[1:0]))
    else $error("read delay write lost");
endmodule : rps_rom_protect_sysconfig
`default_nettype wire

//--- testbench/rps_prog_model.sv
// Programmer model driving the ROM programming port
`default_nettype none
module rps_prog_model (
  // Clock
  input wire logic sys_clk,
  // Programming port
  output rps_pkg::rps_prog_req_t progReq,
  input wire rps_pkg::rps_prog_rsp_t progRsp,
  input wire logic progReady
);
  timeunit 1ns;
  timeprecision 1ps;
  import rps_pkg::*;
  // **********
  // Requests
  // **********
  initial progReq = '0;
  // Hold request until taken, then release with scrambled fields
  task automatic xfer(input rps_cmd_t cmd, input logic inf, input logic [11:0] a,
                      input logic [15:0] wd, output rps_prog_rsp_t rsp);
    rsp = '0;
    @(posedge sys_clk);
    progReq <= '{1'b1, cmd, inf, a, wd};
    do @(posedge sys_clk); while (!progReady);
    progReq <= '{1'b0, cmd, ~inf, ~a, ~wd};
    if (cmd == RPS_RD)
    begin
      @(posedge sys_clk);
      rsp = progRsp;
    end
  endtask : xfer
  // Full erase, waiting while the port is busy
  task automatic erase_all();
    rps_prog_rsp_t r;
    xfer(RPS_ERASE, 1'b0, 12'h000, 16'h0000, r);
    @(posedge sys_clk);
    while (!progReady) @(posedge sys_clk);
  endtask : erase_all
endmodule : rps_prog_model
`default_nettype wire

//--- testbench/test_rom_protect_sysconfig.sv
// Self-checking bench for ROM protection and configuration
`default_nettype none
module test_rom_protect_sysconfig;
  timeunit 1ns;
  timeprecision 1ps;
  import rps_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic avs_response_err;
  rps_prog_req_t progReq;
  rps_prog_rsp_t progRsp;
  rps_prog_rsp_t rsp;
  logic progReady;
  logic irqTake = 1'b0;
  logic extResetPin_n = 1'b1;
  logic [11:0] pc;
  logic [11:0] stackTop;
  logic [11:0] pcSave;
  logic [3:0] stackDepth;
  logic [3:0] depth0;
  logic pinResetReq;
  rps_cfg_out_t cfgOut;
  logic [1:0] readDelay;
  logic [31:0] rd;
  int miscompares = 0;
  int n_checks = 0;
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  // **********
  // Instances
  // **********
  rps_rom_protect_sysconfig dut (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .progReq(progReq), .progRsp(progRsp),
    .progReady(progReady), .irqTake(irqTake), .pc(pc), .stackTop(stackTop), .stackDepth(stackDepth),
    .extResetPin_n(extResetPin_n), .pinResetReq(pinResetReq), .cfgOut(cfgOut),
    .readDelay(readDelay)
  );
  rps_prog_model prog (.sys_clk(sys_clk), .progReq(progReq), .progRsp(progRsp), .progReady(progReady));
  // **********
  // Tasks
  // **********
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Program config word and check decode
  task automatic cfg(input logic [15:0] w, input logic [15:0] exp, input logic [6:0] dec);
    prog.xfer(RPS_WR, 1'b1, 12'h001, w, rsp);
    bus(1'b0, ADDR_SYSTEM_CONFIG_WORD, '0, rd);
    chk(rd, {16'h0000, exp}, "config word");
    chk({25'h0, cfgOut}, {25'h0, dec}, "config decode");
  endtask : cfg
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Watchdog against hangs
  initial
  begin
    #200us;
    miscompares++;
    give_verdict();
  end
  // **********
  // Tests
  // **********
  initial
  begin
    repeat (4) @(posedge sys_clk);
    chk(32'(pc), 32'(RESET_VECTOR), "pc in reset");
    rstn <= 1'b1;
    bus(1'b0, ADDR_RDELAY, '0, rd);
    chk(rd, 32'h1, "delay reset");
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, ADDR_RDELAY, c, rd);
      bus(1'b0, ADDR_RDELAY, '0, rd);
      chk(rd, c, "delay code");
      chk(32'(readDelay), c, "delay port");
    end
    // Lane zero off, the delay write must be dropped
    avs_byteenable <= 4'hE;
    bus(1'b1, ADDR_RDELAY, 32'h0, rd);
    avs_byteenable <= 4'hF;
    bus(1'b0, ADDR_RDELAY, '0, rd);
    chk(rd, 32'h3, "delay lane gate");
    bus(1'b1, ADDR_SYSTEM_CONFIG_WORD, 32'hFFFF, rd);
    bus(1'b1, 12'h7F0, 32'h5, rd);
    @(posedge sys_clk);
    chk(32'(avs_response_err), 32'h1, "unmapped err");
    bus(1'b0, ADDR_SYSTEM_CONFIG_WORD, '0, rd);
    chk(rd, 32'h0, "config read only");
    prog.xfer(RPS_WR, 1'b0, 12'hFFF, 16'hA5C3, rsp);
    prog.xfer(RPS_RD, 1'b0, 12'hFFF, 16'h0000, rsp);
    chk(32'({rsp.refused, rsp.rdata}), 32'h0A5C3, "prog read open");
    prog.xfer(RPS_WR, 1'b1, 12'h01F, 16'h3C5A, rsp);
    prog.xfer(RPS_RD, 1'b1, 12'h01F, 16'h0000, rsp);
    chk(32'(rsp.rdata), 32'h3C5A, "info read open");
    cfg(16'hF700, 16'hF700, 7'b1110111);
    prog.xfer(RPS_RD, 1'b0, 12'hFFF, 16'h0000, rsp);
    chk(32'({rsp.refused, rsp.rdata}), 32'h10000, "prog read locked");
    prog.xfer(RPS_RD, 1'b1, 12'h01F, 16'h0000, rsp);
    chk(32'(rsp.rdata), 32'h3C5A, "info read locked");
    extResetPin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(32'(pinResetReq), 32'h1, "pin reset on");
    cfg(16'h8200, 16'h8200, 7'b0000010);
    chk(32'(pinResetReq), 32'h0, "pin reset off");
    extResetPin_n <= 1'b1;
    cfg(16'h0100, 16'h8100, 7'b0000000);
    prog.erase_all();
    cfg(16'h3C00, 16'h3C00, 7'b0111100);
    prog.xfer(RPS_RD, 1'b0, 12'hFFF, 16'h0000, rsp);
    chk(32'({rsp.refused, rsp.rdata}), 32'h0, "erased read");
    bus(1'b0, ADDR_STATUS, '0, rd);
    chk(rd, 32'h1, "erase flag");
    // Free-running fetch counter steps once before the push
    depth0 = stackDepth;
    pcSave = pc;
    irqTake <= 1'b1;
    @(posedge sys_clk);
    irqTake <= 1'b0;
    @(posedge sys_clk);
    chk(32'({stackDepth, pc}), 32'({depth0 + 4'h1, IRQ_VECTOR}), "irq vector");
    chk(32'(stackTop), 32'(pcSave + 12'h001), "irq push");
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'({cfgOut, readDelay, pc}), 32'({7'h0, RDELAY_RST, RESET_VECTOR}), "second reset");
    rstn <= 1'b1;
    bus(1'b0, ADDR_STATUS, '0, rd);
    chk(rd, 32'h0, "status after reset");
    bus(1'b0, ADDR_RDELAY, '0, rd);
    chk(rd, 32'h1, "delay after reset");
    give_verdict();
  end
endmodule : test_rom_protect_sysconfig
`default_nettype wire
